//--- logic/dsp_interrupt_routing_unit.sv
`timescale 1ns/1ns
`include "irq_cfg.svh"

module dsp_interrupt_routing_unit
	import irq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// peripheral requests
	input wire logic [`NUM_PERIPH-1:0] periph_irq,
	// core event sources
	input wire logic emu_irq,
	input wire logic pwrdn_irq,
	input wire logic kernel_irq,
	// sequencer events
	input wire logic ena_int,
	input wire logic dis_int,
	input wire logic irq_ack,
	input wire logic irq_return,
	input wire logic pc_push,
	input wire logic pc_pop,
	input wire logic loop_push,
	input wire logic loop_pop,
	// io register port
	input wire logic [3:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	// to sequencer
	output logic irq_req,
	output logic [`VEC_W-1:0] irq_vector,
	output logic irq_emu,
	output logic [5:0] pc_depth,
	output logic [3:0] loop_depth,
	output logic [4:0] status_depth
);

	// ****************************************
	// state
	// ****************************************
	word_t map_q [`NUM_MAP];
	word_t mask_q;
	word_t latch_q;
	word_t isr_q;
	word_t stat_mem_q [16];
	logic nest_q;
	logic gie_q;
	logic irq_req_q;
	logic [3:0] idx_q;
	logic [`VEC_W-1:0] irq_vector_q;
	logic irq_emu_q;
	logic [15:0] io_rdata_q;
	pc_depth_t pc_depth_q;
	loop_depth_t loop_depth_q;
	stat_depth_t stat_depth_q;

	logic [`NUM_USER-1:0] user_req;
	word_t src;
	word_t clr;
	word_t latch_d;
	word_t elig;
	word_t nest_ok;
	logic any_sel;
	logic [3:0] sel_idx;
	logic stack_evt;
	logic wr_map;
	logic wr_mask;
	logic wr_ctl;
	logic wr_latch;

	assign wr_map = io_wr && !io_addr[3];
	assign wr_mask = io_wr && (io_addr == `OFF_MASK);
	assign wr_ctl = io_wr && (io_addr == `OFF_CTL);
	assign wr_latch = io_wr && (io_addr == `OFF_LATCH);

	// ****************************************
	// peripheral router
	// ****************************************
	always_ff @(posedge clk) begin
		for (int m = 0; m < `NUM_MAP; m++) begin
			if (!rst_n) begin
				map_q[m] <= `MAP_RESET;
			end else if (wr_map && (io_addr[2:0] == 3'(m))) begin
				map_q[m] <= io_wdata;
			end
		end
	end

	always_comb begin
		code_t code;
		code = '0;
		user_req = '0;
		for (int p = 0; p < `NUM_PERIPH; p++) begin
			code = map_q[p / 4][(p % 4) * `CODE_W +: `CODE_W];
			for (int s = 0; s < `NUM_USER; s++) begin
				// codes above the last slot reach no slot
				if (periph_irq[p] && (code <= `CODE_LAST_SLOT) && (code == 4'(s))) begin
					user_req[s] = 1'b1;
				end
			end
		end
	end

	// ****************************************
	// stacks
	// ****************************************
	assign stack_evt = (pc_push && !pc_pop && (pc_depth_q == `PC_HIGH))
		|| (pc_pop && !pc_push && (pc_depth_q == `PC_LOW));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc_depth_q <= '0;
		end else if (pc_push && !pc_pop && (pc_depth_q != `PC_DEPTH)) begin
			pc_depth_q <= pc_depth_q + 6'h01;
		end else if (pc_pop && !pc_push && (pc_depth_q != 6'h00)) begin
			pc_depth_q <= pc_depth_q - 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loop_depth_q <= '0;
		end else if (loop_push && !loop_pop && (loop_depth_q != `LOOP_DEPTH)) begin
			loop_depth_q <= loop_depth_q + 4'h1;
		end else if (loop_pop && !loop_push && (loop_depth_q != 4'h0)) begin
			loop_depth_q <= loop_depth_q - 4'h1;
		end
	end

	// status stack saves the mask on entry and restores it on return
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_depth_q <= '0;
		end else if (irq_req_q && irq_ack) begin
			if (stat_depth_q != `STAT_DEPTH) begin
				stat_depth_q <= stat_depth_q + 5'h01;
			end
		end else if (irq_return && (stat_depth_q != 5'h00)) begin
			stat_depth_q <= stat_depth_q - 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (irq_req_q && irq_ack && (stat_depth_q != `STAT_DEPTH)) begin
			stat_mem_q[stat_depth_q[3:0]] <= mask_q;
		end
	end

	// ****************************************
	// control, mask and latch
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gie_q <= 1'b0;
			nest_q <= 1'b0;
		end else begin
			if (dis_int) begin
				gie_q <= 1'b0;
			end else if (ena_int) begin
				gie_q <= 1'b1;
			end else if (wr_ctl) begin
				gie_q <= io_wdata[`CTL_GIE];
			end
			if (wr_ctl) begin
				nest_q <= io_wdata[`CTL_NEST];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (irq_return && !(irq_req_q && irq_ack) && (stat_depth_q != 5'h00)) begin
			mask_q <= stat_mem_q[4'(stat_depth_q - 5'h01)];
		end else if (wr_mask) begin
			mask_q <= io_wdata;
		end
	end

	assign src = {user_req, kernel_irq, stack_evt, pwrdn_irq, 1'b0};
	assign clr = (irq_req_q && irq_ack) ? (16'h0001 << idx_q) : 16'h0000;
	// a new request wins over a clear in the same cycle
	assign latch_d = ((wr_latch ? io_wdata : latch_q) & ~clr) | src;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			isr_q <= '0;
		end else if (irq_req_q && irq_ack) begin
			isr_q <= isr_q | clr;
		end else if (irq_return) begin
			isr_q <= isr_q & (isr_q - 16'h0001);
		end
	end

	// ****************************************
	// selection
	// ****************************************
	always_comb begin
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < `NUM_TABLE; i++) begin
			seen = seen | isr_q[i];
			nest_ok[i] = (isr_q == 16'h0000) || (nest_q && !seen);
		end
	end

	assign elig = latch_q & (mask_q | `NONMASK) & nest_ok
		& (gie_q ? 16'hFFFF : (16'h0001 << `IDX_RESET));

	always_comb begin
		any_sel = 1'b0;
		sel_idx = 4'h0;
		for (int i = `NUM_TABLE - 1; i >= 0; i--) begin
			if (elig[i]) begin
				any_sel = 1'b1;
				sel_idx = 4'(i);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_req_q <= 1'b0;
			idx_q <= '0;
			irq_vector_q <= '0;
			irq_emu_q <= 1'b0;
		end else begin
			irq_emu_q <= emu_irq;
			irq_req_q <= any_sel && !emu_irq && !(irq_req_q && irq_ack);
			idx_q <= sel_idx;
			irq_vector_q <= `VEC_W'(sel_idx) << `VEC_SHIFT;
		end
	end

	// ****************************************
	// io read
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_rdata_q <= '0;
		end else if (!io_rd) begin
			io_rdata_q <= '0;
		end else if (!io_addr[3]) begin
			io_rdata_q <= map_q[io_addr[2:0]];
		end else begin
			case (io_addr)
				`OFF_MASK: io_rdata_q <= mask_q;
				`OFF_CTL: io_rdata_q <= {14'h0000, gie_q, nest_q};
				`OFF_LATCH: io_rdata_q <= latch_q;
				`OFF_ISR: io_rdata_q <= isr_q;
				default: io_rdata_q <= '0;
			endcase
		end
	end

	assign io_rdata = io_rdata_q;
	assign irq_req = irq_req_q;
	assign irq_vector = irq_vector_q;
	assign irq_emu = irq_emu_q;
	assign pc_depth = pc_depth_q;
	assign loop_depth = loop_depth_q;
	assign status_depth = stat_depth_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		irq_req_q && irq_ack && (stat_depth_q != `STAT_DEPTH);
	endsequence

	a_gie_after_reset: assert property ($rose(rst_n) |-> !gie_q && !irq_req_q)
		else $error("interrupts enabled after reset");
	a_mask_gate: assert property (irq_req_q |->
		((($past(latch_q & (mask_q | `NONMASK))) >> idx_q) & 16'h0001) != 16'h0000)
		else $error("masked interrupt requested");
	a_prio_pick: assert property (irq_req_q |->
		($past(elig) & ((16'h0001 << idx_q) - 16'h0001)) == 16'h0000)
		else $error("lower priority chosen over higher");
	a_vector_map: assert property (irq_req_q |->
		irq_vector_q == ({20'h0_0000, idx_q} << `VEC_SHIFT))
		else $error("vector does not match index");
	a_gdis_block: assert property (!gie_q ##1 irq_req_q |-> idx_q == `IDX_RESET)
		else $error("request while globally disabled");
	a_nest_only: assert property (irq_req_q && ($past(isr_q) != 16'h0000) |-> $past(nest_q))
		else $error("preemption without nesting");
	a_force_latch: assert property (wr_latch && !irq_ack |=>
		(latch_q & $past(io_wdata)) == $past(io_wdata))
		else $error("forced latch bit lost");
	a_stack_level: assert property (pc_push && !pc_pop && (pc_depth_q == `PC_HIGH) |=>
		latch_q[`IDX_STACK] && (pc_depth_q == `PC_HIGH + 6'h01))
		else $error("stack level event missed");
	a_status_push: assert property (s_take |=>
		(stat_depth_q == $past(stat_depth_q) + 5'h01) && !irq_req_q)
		else $error("status not pushed on entry");
	a_route_reset: assert property ($rose(rst_n) |-> user_req == '0)
		else $error("routing active after reset");

endmodule // dsp_interrupt_routing_unit

//--- logic/irq_cfg.svh
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
// table interrupt numbering (0 = highest priority after the emulator)
`define NUM_TABLE 16
`define NUM_USER 12
`define USER_BASE 4
`define IDX_RESET 4'h0
`define IDX_PWRDN 4'h1
`define IDX_STACK 4'h2
`define IDX_KERNEL 4'h3
`define NONMASK 16'h0003
`define VEC_SHIFT 5
`define VEC_W 24
// peripheral router
`define NUM_PERIPH 32
`define NUM_MAP 8
`define CODE_W 4
`define CODE_LAST_SLOT 4'hB
`define MAP_RESET 16'hFFFF
// io register offsets
`define OFF_MASK 4'h8
`define OFF_CTL 4'h9
`define OFF_LATCH 4'hA
`define OFF_ISR 4'hB
`define CTL_NEST 0
`define CTL_GIE 1
// stack depths and stack-level thresholds
`define PC_DEPTH 6'h21
`define LOOP_DEPTH 4'h8
`define STAT_DEPTH 5'h10
`define PC_LOW 6'h03
`define PC_HIGH 6'h1C
`endif

//--- logic/irq_pkg.sv
package irq_pkg;
	typedef logic [15:0] word_t;
	typedef logic [3:0] code_t;
	typedef logic [5:0] pc_depth_t;
	typedef logic [4:0] stat_depth_t;
	typedef logic [3:0] loop_depth_t;
endpackage

//--- tb/seq_model.sv
`timescale 1ns/1ns
module seq_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// from the interrupt unit
	input wire logic irq_req,
	input wire logic [23:0] irq_vector,
	// response delay and observed result
	input wire logic [3:0] dly,
	output logic irq_ack,
	output logic [23:0] vec_q,
	output logic [7:0] n_ack
);
	logic [3:0] cnt;
	// ************
	// acknowledge
	// ************
	// ack rises on a falling edge so it is stable over the taking edge
	always @(negedge clk) begin
		if (!rst_n || irq_ack || !irq_req) begin
			irq_ack <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt == dly) begin
			irq_ack <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			n_ack <= 8'h00;
		end else if (irq_ack && irq_req) begin
			vec_q <= irq_vector;
			n_ack <= n_ack + 8'h01;
		end
	end
endmodule // seq_model

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic clk, rst_n, pwrdn_irq, ena_int, dis_int, irq_return, pc_push, pc_pop;
	logic emu_irq, kernel_irq, loop_push, loop_pop;
	logic io_wr, io_rd, irq_req, irq_ack, irq_emu;
	logic [31:0] periph_irq;
	logic [3:0] io_addr, dly, loop_depth;
	logic [15:0] io_wdata, io_rdata;
	logic [23:0] irq_vector, vec_q;
	logic [5:0] pc_depth;
	logic [4:0] status_depth;
	logic [7:0] n_ack;
	int fails = 0;
	int tests_run = 0;
	int c;
	dsp_interrupt_routing_unit dut_u (.clk(clk), .rst_n(rst_n), .periph_irq(periph_irq),
		.emu_irq(emu_irq), .pwrdn_irq(pwrdn_irq), .kernel_irq(kernel_irq), .ena_int(ena_int),
		.dis_int(dis_int), .irq_ack(irq_ack), .irq_return(irq_return), .pc_push(pc_push),
		.pc_pop(pc_pop), .loop_push(loop_push), .loop_pop(loop_pop), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_emu(irq_emu),
		.pc_depth(pc_depth), .loop_depth(loop_depth), .status_depth(status_depth));
	seq_model seq_u (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .irq_vector(irq_vector),
		.dly(dly), .irq_ack(irq_ack), .vec_q(vec_q), .n_ack(n_ack));
	// ************
	// tasks
	// ************
	task chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		chk(io_rdata, exp);
	endtask
	task none;
		repeat (4) @(negedge clk);
		chk(irq_req, 1'b0);
		periph_irq = '0;
	endtask
	task take(input logic [23:0] exp, input logic [4:0] dep);
		logic [7:0] n;
		int i;
		n = n_ack;
		for (i = 0; i < 20 && irq_req !== 1'b1; i++) @(negedge clk);
		periph_irq = '0;
		pwrdn_irq = 1'b0;
		kernel_irq = 1'b0;
		for (i = 0; i < 20 && n_ack === n; i++) @(negedge clk);
		chk(vec_q, exp);
		chk(status_depth, dep);
	endtask
	task ret;
		@(negedge clk);
		irq_return = 1'b1;
		@(negedge clk);
		irq_return = 1'b0;
	endtask
	task serve(input logic [23:0] exp);
		take(exp, 5'h01);
		ret();
	endtask
	task pc(input int n, input logic up);
		repeat (n) begin
			@(negedge clk);
			pc_push = up;
			pc_pop = !up;
		end
		@(negedge clk);
		pc_push = 1'b0;
		pc_pop = 1'b0;
	endtask
	task lp(input int n, input logic up);
		repeat (n) begin
			@(negedge clk);
			loop_push = up;
			loop_pop = !up;
		end
		@(negedge clk);
		loop_push = 1'b0;
		loop_pop = 1'b0;
	endtask
	task pulse_gie(input logic en);
		@(negedge clk);
		ena_int = en;
		dis_int = !en;
		@(negedge clk);
		ena_int = 1'b0;
		dis_int = 1'b0;
	endtask
	task print_verdict;
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ************
	// sequence
	// ************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		fails++;
		print_verdict;
	end
	initial begin
		{rst_n, pwrdn_irq, emu_irq, kernel_irq, ena_int, dis_int, irq_return} = '0;
		{pc_push, pc_pop, loop_push, loop_pop, io_wr, io_rd} = '0;
		periph_irq = '0;
		io_addr = 4'h0;
		io_wdata = 16'h0000;
		dly = 4'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		rd(4'h0, 16'hFFFF);
		rd(4'h7, 16'hFFFF);
		rd(4'h9, 16'h0000);
		wr(4'hC, 16'h1234);
		rd(4'hC, 16'h0000);
		wr(4'h8, 16'hFFFF);
		wr(4'h9, 16'h0002);
		rd(4'h9, 16'h0002);
		periph_irq[5] = 1'b1;
		none();
		for (c = 0; c < 16; c++) begin
			wr(4'h1, {8'hFF, c[3:0], 4'hF});
			rd(4'h1, {8'hFF, c[3:0], 4'hF});
			periph_irq[5] = 1'b1;
			if (c < 12)
				serve(24'((c + 4) * 32));
			else
				none();
		end
		wr(4'h7, 16'h5FFF);
		periph_irq[31] = 1'b1;
		serve(24'h00_0120);
		wr(4'h7, 16'hFFFF);
		dly = 4'h3;
		wr(4'h0, 16'hFF13);
		periph_irq[1:0] = 2'b11;
		serve(24'h00_00A0);
		serve(24'h00_00E0);
		wr(4'h0, 16'hFF22);
		for (c = 0; c < 2; c++) begin
			periph_irq[c] = 1'b1;
			serve(24'h00_00C0);
		end
		wr(4'h8, 16'hFFBF);
		periph_irq[0] = 1'b1;
		none();
		wr(4'h8, 16'hFFFF);
		serve(24'h00_00C0);
		pulse_gie(1'b0);
		wr(4'hA, 16'h0040);
		none();
		wr(4'hA, 16'h0041);
		serve(24'h00_0000);
		rd(4'hA, 16'h0040);
		wr(4'hA, 16'h0000);
		pulse_gie(1'b1);
		none();
		wr(4'hA, 16'h0040);
		serve(24'h00_00C0);
		emu_irq = 1'b1;
		kernel_irq = 1'b1;
		none();
		chk(irq_emu, 1'b1);
		emu_irq = 1'b0;
		serve(24'h00_0060);
		chk(irq_emu, 1'b0);
		wr(4'h0, 16'hFFB0);
		periph_irq[1] = 1'b1;
		take(24'h00_01E0, 5'h01);
		periph_irq[0] = 1'b1;
		none();
		ret();
		serve(24'h00_0080);
		wr(4'h9, 16'h0003);
		rd(4'h9, 16'h0003);
		periph_irq[1] = 1'b1;
		take(24'h00_01E0, 5'h01);
		periph_irq[0] = 1'b1;
		take(24'h00_0080, 5'h02);
		rd(4'hB, 16'h8010);
		ret();
		ret();
		chk(status_depth, 5'h00);
		lp(9, 1'b1);
		chk(loop_depth, 4'h8);
		lp(9, 1'b0);
		chk(loop_depth, 4'h0);
		pc(29, 1'b1);
		chk(pc_depth, 6'h1D);
		serve(24'h00_0040);
		pc(27, 1'b0);
		serve(24'h00_0040);
		wr(4'h8, 16'h0000);
		pulse_gie(1'b0);
		pwrdn_irq = 1'b1;
		none();
		pulse_gie(1'b1);
		serve(24'h00_0020);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd(4'h9, 16'h0000);
		rd(4'h0, 16'hFFFF);
		chk(pc_depth, 6'h00);
		print_verdict;
	end
endmodule // tb_top
